// [register_move_datapath_test.sv]
// Self-checking bench for the register-move datapath: Avalon-MM tasks and command sequences.
// Assumes the register map of regmove_map.svh and a 10 MHz clock with synchronous active-low reset.
`include "regmove_map.svh"

module register_move_datapath_test;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int LIMIT = 20000;
  localparam logic [31:0] VA = 32'h1234_5678;
  localparam logic [31:0] VB = 32'h9abc_def0;
  localparam logic [31:0] VC = 32'h0bad_cafe;
  localparam logic [31:0] VD = 32'h5a5a_0001;
  localparam logic [31:0] VE = 32'ha5a5_0002;

  logic clk_sys;
  logic rstn;
  logic [7:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic [31:0] rd;
  logic [31:0] st;
  int mismatches;
  int checks;
  int cycles;

  regmove_datapath u_dut (.clk_sys(clk_sys), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));

  // Free-running clock, 100 ns period
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Request held until waitrequest is sampled low, then released
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    address <= a;
    read <= 1'b1;
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
  endtask

  // Issue one command, wait for idle, compare the exception field
  task automatic do_op(input regmove_pkg::op_t o, input regmove_pkg::fmt_t f, input logic [2:0] c,
    input logic [4:0] s, input logic [4:0] d, input logic [1:0] exc);
    regmove_pkg::cmd_t w;
    w = '0;
    w.op = o;
    w.operand_format_field = f;
    w.cond_flag_index = c;
    w.src = s;
    w.dst = d;
    bus_write(`RM_OFF_CMD, w);
    do bus_read(`RM_OFF_STATUS, st); while (st[0] !== 1'b0);
    check({30'h0, st[2:1]}, {30'h0, exc});
  endtask

  task automatic ld_fp(input logic [4:0] i, input logic [31:0] hi, input logic [31:0] lo);
    bus_write(`RM_OFF_WDATA, lo);
    bus_write(`RM_OFF_WDATA_HI, hi);
    do_op(regmove_pkg::OP_LOAD_FP, regmove_pkg::FMT_SINGLE, 3'h0, 5'h0, i, 2'h0);
  endtask

  task automatic ld_int(input logic [4:0] i, input logic [31:0] v);
    bus_write(`RM_OFF_WDATA, v);
    do_op(regmove_pkg::OP_LOAD_INT, regmove_pkg::FMT_SINGLE, 3'h0, 5'h0, i, 2'h0);
  endtask

  task automatic rd_int(input logic [4:0] i, input logic [31:0] exp);
    do_op(regmove_pkg::OP_READ_INT, regmove_pkg::FMT_SINGLE, 3'h0, i, 5'h0, 2'h0);
    bus_read(`RM_OFF_RESULT, rd);
    check(rd, exp);
  endtask

  task automatic rd_fp(input logic [4:0] i, input logic [31:0] hi, input logic [31:0] lo);
    do_op(regmove_pkg::OP_READ_FP, regmove_pkg::FMT_SINGLE, 3'h0, i, 5'h0, 2'h0);
    bus_read(`RM_OFF_RESULT, rd);
    check(rd, lo);
    bus_read(`RM_OFF_RESULT_HI, rd);
    check(rd, hi);
  endtask

  // Main sequence
  initial begin
    rstn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    bus_read(`RM_OFF_CFG, rd);
    check(rd, 32'h0000_001f);
    bus_read(`RM_OFF_FCC, rd);
    check(rd, 32'h0);
    bus_write(8'h30, 32'hffff_ffff);
    bus_read(8'h30, rd);
    check(rd, 32'h0);
    $display("test reset done");
    // Copies out to integer registers
    ld_fp(5'h03, VB, VA);
    do_op(regmove_pkg::OP_FPU_COPY_OUT, regmove_pkg::FMT_SINGLE, 3'h0, 5'h03, 5'h05, 2'h0);
    rd_int(5'h05, VA);
    do_op(regmove_pkg::OP_FPU_UPPER_COPY, regmove_pkg::FMT_SINGLE, 3'h0, 5'h03, 5'h06, 2'h0);
    rd_int(5'h06, VB);
    bus_write(`RM_OFF_WDATA, VC);
    do_op(regmove_pkg::OP_LOAD_COP0, regmove_pkg::FMT_SINGLE, 3'h0, 5'h02, 5'h00, 2'h0);
    do_op(regmove_pkg::OP_SYS_CTL_COPY_OUT, regmove_pkg::FMT_SINGLE, 3'h0, 5'h02, 5'h07, 2'h0);
    rd_int(5'h07, VC);
    ld_fp(5'h00, VE, VD);
    do_op(regmove_pkg::OP_LOAD_COP2, regmove_pkg::FMT_SINGLE, 3'h0, 5'h01, 5'h00, 2'h0);
    do_op(regmove_pkg::OP_COP_TWO_COPY_OUT, regmove_pkg::FMT_SINGLE, 3'h0, 5'h01, 5'h08, 2'h0);
    rd_int(5'h08, VD);
    do_op(regmove_pkg::OP_COP_TWO_UPPER_COPY, regmove_pkg::FMT_SINGLE, 3'h0, 5'h01, 5'h09, 2'h0);
    rd_int(5'h09, VE);
    bus_write(`RM_OFF_HI, VD);
    bus_write(`RM_OFF_LO, VE);
    do_op(regmove_pkg::OP_UPPER_MUL_COPY, regmove_pkg::FMT_SINGLE, 3'h0, 5'h00, 5'h0a, 2'h0);
    rd_int(5'h0a, VD);
    do_op(regmove_pkg::OP_BOTTOM_MUL_COPY, regmove_pkg::FMT_SINGLE, 3'h0, 5'h00, 5'h0b, 2'h0);
    rd_int(5'h0b, VE);
    $display("test copy_out done");
    // Register copies and conditional moves
    ld_fp(5'h0c, 32'h0, 32'h0);
    do_op(regmove_pkg::OP_FP_REG_COPY, regmove_pkg::FMT_DOUBLE, 3'h0, 5'h03, 5'h0c, 2'h0);
    rd_fp(5'h0c, VB, VA);
    do_op(regmove_pkg::OP_FP_REG_COPY, regmove_pkg::FMT_PAIRED_SINGLE, 3'h0, 5'h00, 5'h0c, 2'h0);
    rd_fp(5'h0c, VE, VD);
    // Single format replaces the low word and keeps the target's high word
    do_op(regmove_pkg::OP_FP_REG_COPY, regmove_pkg::FMT_SINGLE, 3'h0, 5'h03, 5'h0c, 2'h0);
    rd_fp(5'h0c, VE, VA);
    bus_write(`RM_OFF_FCC, 32'h0000_0006);
    ld_int(5'h0e, 32'h0);
    do_op(regmove_pkg::OP_INT_MOVE_IF_COND_CLEAR, regmove_pkg::FMT_SINGLE, 3'h1, 5'h05, 5'h0e, 2'h0);
    rd_int(5'h0e, 32'h0);
    // Move on flag 0 from 5 to 14; the flag write right behind it must wait until the move is done
    bus_write(`RM_OFF_CMD, 32'h0003_8a08);
    bus_write(`RM_OFF_FCC, 32'h0000_0001);
    do bus_read(`RM_OFF_STATUS, st); while (st[0] !== 1'b0);
    check({27'h0, st[4:0]}, 32'h0000_0010);
    rd_int(5'h0e, VA);
    ld_fp(5'h0f, VC, VD);
    bus_write(`RM_OFF_FCC, 32'h0000_0004);
    do_op(regmove_pkg::OP_FP_MOVE_IF_COND_CLEAR, regmove_pkg::FMT_PAIRED_SINGLE, 3'h2, 5'h03, 5'h0f, 2'h0);
    rd_fp(5'h0f, VB, VD);
    do_op(regmove_pkg::OP_FP_MOVE_IF_COND_CLEAR, regmove_pkg::FMT_DOUBLE, 3'h2, 5'h00, 5'h0f, 2'h0);
    rd_fp(5'h0f, VB, VD);
    do_op(regmove_pkg::OP_FP_MOVE_IF_COND_CLEAR, regmove_pkg::FMT_DOUBLE, 3'h0, 5'h00, 5'h0f, 2'h0);
    rd_fp(5'h0f, VE, VD);
    $display("test moves done");
    // Exceptions and unpredictable outcomes
    bus_write(`RM_OFF_CFG, 32'h0000_001e);
    do_op(regmove_pkg::OP_FPU_UPPER_COPY, regmove_pkg::FMT_SINGLE, 3'h0, 5'h03, 5'h10, 2'h2);
    do_op(regmove_pkg::OP_COP_TWO_UPPER_COPY, regmove_pkg::FMT_SINGLE, 3'h0, 5'h01, 5'h10, 2'h2);
    bus_write(`RM_OFF_CFG, 32'h0000_000f);
    do_op(regmove_pkg::OP_COP_TWO_COPY_OUT, regmove_pkg::FMT_SINGLE, 3'h0, 5'h01, 5'h10, 2'h1);
    bus_write(`RM_OFF_CFG, 32'h0000_001b);
    do_op(regmove_pkg::OP_SYS_CTL_COPY_OUT, regmove_pkg::FMT_SINGLE, 3'h0, 5'h02, 5'h10, 2'h1);
    bus_write(`RM_OFF_CFG, 32'h0000_0017);
    do_op(regmove_pkg::OP_FPU_COPY_OUT, regmove_pkg::FMT_SINGLE, 3'h0, 5'h03, 5'h10, 2'h1);
    bus_write(`RM_OFF_CFG, 32'h0000_0000);
    do_op(regmove_pkg::OP_UPPER_MUL_COPY, regmove_pkg::FMT_SINGLE, 3'h0, 5'h00, 5'h10, 2'h0);
    bus_write(`RM_OFF_CFG, 32'h0000_001f);
    do_op(regmove_pkg::OP_FP_REG_COPY, regmove_pkg::FMT_RESERVED, 3'h0, 5'h03, 5'h10, 2'h3);
    do_op(regmove_pkg::OP_SYS_CTL_COPY_OUT, regmove_pkg::FMT_SINGLE, 3'h0, 5'h09, 5'h10, 2'h0);
    check({31'h0, st[3]}, 32'h1);
    do_op(regmove_pkg::OP_COP_TWO_UPPER_COPY, regmove_pkg::FMT_SINGLE, 3'h0, 5'h05, 5'h10, 2'h0);
    check({31'h0, st[3]}, 32'h1);
    bus_write(`RM_OFF_CFG, 32'h0000_001d);
    do_op(regmove_pkg::OP_FP_REG_COPY, regmove_pkg::FMT_PAIRED_SINGLE, 3'h0, 5'h03, 5'h10, 2'h0);
    check({31'h0, st[3]}, 32'h1);
    $display("test exceptions done");
    wrap_up();
  end
endmodule

// [regmove_datapath.sv]
// Register-move datapath with its integer and floating-point register files.
// Assumes an Avalon-MM master on clk_sys; software loads operands and issues commands.
//
// Contract
// - Coprocessor-0 copy-out loads register chosen by number and sub-index into dest.
// - Copy-out of a missing coprocessor-0 register gives an undefined result.
// - Coprocessor-0 and FP copy-out raise only unusable or reserved-instruction.
// - FP copy-out moves one raw word from FP source to integer dest.
// - Coprocessor-2 copy-out loads its named register; only unusable may occur.
// - FP upper copy loads bits 63..32 of the FP source into dest.
// - Before release 2 both upper copies raise reserved-instruction.
// - Coprocessor-2 upper copy moves upper word; missing register is unpredictable.
// - Upper multiply half copies to the integer target without exception.
// - Bottom multiply half copies to the integer target without exception.
// - FP register copy moves source to target in format; paired copies both halves.
// - FP copies and conditional moves raise no arithmetic exception, only unimplemented.
// - Paired moves in 16-register mode give unpredictable results.
// - Integer move copies source to target only when the condition flag is 0.
// - FP conditional move copies source to target when the flag is zero.
// - FP conditional move keeps the target unchanged when the flag is set.
// - An unchanged target not holding a format value becomes unpredictable; the code writes back the old target word and sets no unpredictable flag.
// - Paired conditional move merges low half on flag, high half on next flag.
//
// Design decisions made here: register access over Avalon-MM and the register offsets.
`include "regmove_map.svh"

module regmove_datapath (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest
);

  regmove_pkg::cmd_t cmd_reg;
  regmove_pkg::state_t state_reg;
  regmove_pkg::exc_t exc_reg;
  regmove_pkg::exc_t exc_next;
  logic [4:0] cfg_reg;
  logic [7:0] fcc_reg;
  logic [31:0] hi_reg;
  logic [31:0] lo_reg;
  logic [31:0] wdata_reg;
  logic [31:0] wdata_hi_reg;
  logic [31:0] result_reg;
  logic [31:0] result_hi_reg;
  logic [31:0] readdata_reg;
  logic rd_ack_reg;
  logic unpred_reg;
  logic unpred_next;
  logic moved_reg;
  logic moved_next;
  logic [31:0] cop0_reg [8];
  logic [63:0] cop2_reg [4];
  logic [31:0] int_a;
  logic [63:0] fp_a;
  logic [63:0] fp_b;
  logic int_we;
  logic [31:0] int_wd;
  logic fp_we;
  logic [63:0] fp_wd;
  logic res_we;
  logic [63:0] res_val;
  logic exec;
  logic busy;
  logic bus_wr;
  logic flag_lo;
  logic flag_hi;
  logic cop0_hit;
  logic cop2_hit;

  // Coprocessor-usable check for an operation
  function automatic logic op_usable(input regmove_pkg::op_t op, input logic [4:0] cfg);
    logic ok;
    ok = 1'b1;
    case (op)
      regmove_pkg::OP_SYS_CTL_COPY_OUT: ok = cfg[`RM_CFG_CU0];
      regmove_pkg::OP_COP_TWO_COPY_OUT, regmove_pkg::OP_COP_TWO_UPPER_COPY: ok = cfg[`RM_CFG_CU2];
      regmove_pkg::OP_FPU_COPY_OUT, regmove_pkg::OP_FPU_UPPER_COPY, regmove_pkg::OP_FP_REG_COPY,
      regmove_pkg::OP_INT_MOVE_IF_COND_CLEAR, regmove_pkg::OP_FP_MOVE_IF_COND_CLEAR: ok = cfg[`RM_CFG_CU1];
      default: ok = 1'b1;
    endcase
    return ok;
  endfunction

  assign exec = (state_reg == regmove_pkg::ST_EXEC);
  assign busy = (state_reg != regmove_pkg::ST_IDLE);
  assign bus_wr = write && !busy;
  assign flag_lo = fcc_reg[cmd_reg.cond_flag_index];
  assign flag_hi = fcc_reg[3'(cmd_reg.cond_flag_index + 3'h1)];
  assign cop0_hit = ({1'b0, cmd_reg.src[2:0]} < `RM_COP0_REGS) && (cmd_reg.src[4:3] == 2'h0)
                    && (cmd_reg.sub_index_field == 3'h0);
  assign cop2_hit = (cmd_reg.src < `RM_COP2_REGS);

  // Reads take one wait cycle so read data come from a register; writes wait while busy
  assign waitrequest = (read && !rd_ack_reg) || (write && busy);
  assign readdata = readdata_reg;

  // Register files
  regmove_mem #(.WIDTH(32)) int_mem (
    .clk_sys(clk_sys),
    .raddr_a(cmd_reg.src),
    .raddr_b(cmd_reg.dst),
    .rdata_a(int_a),
    .rdata_b(),
    .we(int_we),
    .waddr(cmd_reg.dst),
    .wdata(int_wd)
  );

  regmove_mem #(.WIDTH(64)) fp_mem (
    .clk_sys(clk_sys),
    .raddr_a(cmd_reg.src),
    .raddr_b(cmd_reg.dst),
    .rdata_a(fp_a),
    .rdata_b(fp_b),
    .we(fp_we),
    .waddr(cmd_reg.dst),
    .wdata(fp_wd)
  );

  // Read data register and read handshake
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rd_ack_reg <= 1'b0;
      readdata_reg <= 32'h0;
    end else if (read && !rd_ack_reg) begin
      rd_ack_reg <= 1'b1;
      if (address == `RM_OFF_CMD) begin
        readdata_reg <= cmd_reg;
      end else if (address == `RM_OFF_CFG) begin
        readdata_reg <= {27'h0, cfg_reg};
      end else if (address == `RM_OFF_STATUS) begin
        readdata_reg <= {27'h0, moved_reg, unpred_reg, exc_reg, busy};
      end else if (address == `RM_OFF_RESULT) begin
        readdata_reg <= result_reg;
      end else if (address == `RM_OFF_RESULT_HI) begin
        readdata_reg <= result_hi_reg;
      end else if (address == `RM_OFF_FCC) begin
        readdata_reg <= {24'h0, fcc_reg};
      end else if (address == `RM_OFF_HI) begin
        readdata_reg <= hi_reg;
      end else if (address == `RM_OFF_LO) begin
        readdata_reg <= lo_reg;
      end else if (address == `RM_OFF_WDATA) begin
        readdata_reg <= wdata_reg;
      end else if (address == `RM_OFF_WDATA_HI) begin
        readdata_reg <= wdata_hi_reg;
      end else begin
        readdata_reg <= 32'h0;
      end
    end else begin
      rd_ack_reg <= 1'b0;
    end
  end

  // Software-written configuration and operand registers
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cfg_reg <= `RM_CFG_RESET;
      fcc_reg <= `RM_FCC_RESET;
      hi_reg <= 32'h0;
      lo_reg <= 32'h0;
      wdata_reg <= 32'h0;
      wdata_hi_reg <= 32'h0;
    end else if (bus_wr) begin
      if (address == `RM_OFF_CFG) begin
        cfg_reg <= writedata[4:0];
      end else if (address == `RM_OFF_FCC) begin
        fcc_reg <= writedata[7:0];
      end else if (address == `RM_OFF_HI) begin
        hi_reg <= writedata;
      end else if (address == `RM_OFF_LO) begin
        lo_reg <= writedata;
      end else if (address == `RM_OFF_WDATA) begin
        wdata_reg <= writedata;
      end else if (address == `RM_OFF_WDATA_HI) begin
        wdata_hi_reg <= writedata;
      end
    end
  end

  // Sequencer: a command write starts read, then execute, then back to idle
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_reg <= regmove_pkg::ST_IDLE;
      cmd_reg <= '0;
    end else begin
      case (state_reg)
        regmove_pkg::ST_IDLE: begin
          if (bus_wr && address == `RM_OFF_CMD) begin
            cmd_reg <= regmove_pkg::cmd_t'(writedata);
            state_reg <= regmove_pkg::ST_READ;
          end
        end
        regmove_pkg::ST_READ: state_reg <= regmove_pkg::ST_EXEC;
        default: state_reg <= regmove_pkg::ST_IDLE;
      endcase
    end
  end

  // Execution: picks the written value, its target and the exception outcome
  always_comb begin
    exc_next = regmove_pkg::EXC_NONE;
    unpred_next = 1'b0;
    moved_next = 1'b0;
    int_we = 1'b0;
    int_wd = int_a;
    fp_we = 1'b0;
    fp_wd = fp_b;
    if (exec && !op_usable(cmd_reg.op, cfg_reg)) begin
      exc_next = regmove_pkg::EXC_COP_UNUSABLE;
    end else if (exec) begin
      case (cmd_reg.op)
        regmove_pkg::OP_SYS_CTL_COPY_OUT: begin
          int_we = 1'b1;
          int_wd = cop0_hit ? cop0_reg[cmd_reg.src[2:0]] : 32'h0;
          unpred_next = !cop0_hit;
        end
        regmove_pkg::OP_FPU_COPY_OUT: begin
          int_we = 1'b1;
          int_wd = fp_a[31:0];
        end
        regmove_pkg::OP_COP_TWO_COPY_OUT: begin
          int_we = 1'b1;
          int_wd = cop2_hit ? cop2_reg[cmd_reg.src[1:0]][31:0] : 32'h0;
          unpred_next = !cop2_hit;
        end
        regmove_pkg::OP_FPU_UPPER_COPY, regmove_pkg::OP_COP_TWO_UPPER_COPY: begin
          if (!cfg_reg[`RM_CFG_REL2]) begin
            exc_next = regmove_pkg::EXC_RESERVED_INSTR;
          end else if (cmd_reg.op == regmove_pkg::OP_FPU_UPPER_COPY) begin
            int_we = 1'b1;
            int_wd = fp_a[63:32];
          end else begin
            int_we = 1'b1;
            int_wd = cop2_hit ? cop2_reg[cmd_reg.src[1:0]][63:32] : 32'h0;
            unpred_next = !cop2_hit;
          end
        end
        regmove_pkg::OP_UPPER_MUL_COPY: begin
          int_we = 1'b1;
          int_wd = hi_reg;
        end
        regmove_pkg::OP_BOTTOM_MUL_COPY: begin
          int_we = 1'b1;
          int_wd = lo_reg;
        end
        regmove_pkg::OP_INT_MOVE_IF_COND_CLEAR: begin
          int_we = !flag_lo;
          moved_next = !flag_lo;
        end
        regmove_pkg::OP_FP_REG_COPY, regmove_pkg::OP_FP_MOVE_IF_COND_CLEAR: begin
          if (cmd_reg.operand_format_field == regmove_pkg::FMT_RESERVED) begin
            exc_next = regmove_pkg::EXC_UNIMPL_OP;
          end else begin
            fp_we = 1'b1;
            if (cmd_reg.op == regmove_pkg::OP_FP_REG_COPY) begin
              moved_next = 1'b1;
              // Single format writes the low word only; double and paired copy both halves
              if (cmd_reg.operand_format_field == regmove_pkg::FMT_SINGLE) begin
                fp_wd = {fp_b[63:32], fp_a[31:0]};
              end else begin
                fp_wd = fp_a;
              end
            end else if (cmd_reg.operand_format_field == regmove_pkg::FMT_PAIRED_SINGLE) begin
              // Each half is merged under its own flag; a half whose flag is set keeps the target
              fp_wd = {flag_hi ? fp_b[63:32] : fp_a[63:32], flag_lo ? fp_b[31:0] : fp_a[31:0]};
              moved_next = !flag_lo || !flag_hi;
              unpred_next = cmd_reg.cond_flag_index[0];
            end else begin
              // A set flag writes back the old target word, leaving it as it was
              fp_wd = flag_lo ? fp_b : fp_a;
              moved_next = !flag_lo;
            end
            if (cmd_reg.operand_format_field == regmove_pkg::FMT_PAIRED_SINGLE && !cfg_reg[`RM_CFG_FR64]) begin
              unpred_next = 1'b1;
            end
          end
        end
        regmove_pkg::OP_LOAD_INT: begin
          int_we = 1'b1;
          int_wd = wdata_reg;
        end
        regmove_pkg::OP_LOAD_FP: begin
          fp_we = 1'b1;
          fp_wd = {wdata_hi_reg, wdata_reg};
        end
        default: begin
        end
      endcase
    end
  end

  // Result register shows the last value written or read back
  always_comb begin
    res_we = int_we || fp_we;
    res_val = int_we ? {32'h0, int_wd} : fp_wd;
    if (exec && cmd_reg.op == regmove_pkg::OP_READ_INT) begin
      res_we = 1'b1;
      res_val = {32'h0, int_a};
    end else if (exec && cmd_reg.op == regmove_pkg::OP_READ_FP) begin
      res_we = 1'b1;
      res_val = fp_a;
    end
  end

  // Status and result registers
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      exc_reg <= regmove_pkg::EXC_NONE;
      unpred_reg <= 1'b0;
      moved_reg <= 1'b0;
      result_reg <= 32'h0;
      result_hi_reg <= 32'h0;
    end else if (exec) begin
      exc_reg <= exc_next;
      unpred_reg <= unpred_next;
      moved_reg <= moved_next;
      if (res_we) begin
        result_reg <= res_val[31:0];
        result_hi_reg <= res_val[63:32];
      end
    end
  end

  // Coprocessor banks loaded by command
  always_ff @(posedge clk_sys) begin
    if (exec && cmd_reg.op == regmove_pkg::OP_LOAD_COP0 && cop0_hit) begin
      cop0_reg[cmd_reg.src[2:0]] <= wdata_reg;
    end
    if (exec && cmd_reg.op == regmove_pkg::OP_LOAD_COP2 && cop2_hit) begin
      cop2_reg[cmd_reg.src[1:0]] <= {wdata_hi_reg, wdata_reg};
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  chk_cmd_sequence: assert property (
    (bus_wr && address == `RM_OFF_CMD) |=> (state_reg == regmove_pkg::ST_READ) ##1 exec ##1 !busy)
    else $error("command did not run read, execute, idle");
  chk_sys_ctl_read: assert property (
    (exec && cmd_reg.op == regmove_pkg::OP_SYS_CTL_COPY_OUT && cfg_reg[`RM_CFG_CU0] && cop0_hit)
    |-> int_we && int_wd == cop0_reg[cmd_reg.src[2:0]] ##1 result_reg == $past(int_wd))
    else $error("coprocessor 0 copy-out wrong");
  chk_sys_ctl_missing: assert property (
    (exec && cmd_reg.op == regmove_pkg::OP_SYS_CTL_COPY_OUT && cfg_reg[`RM_CFG_CU0] && !cop0_hit) |=> unpred_reg)
    else $error("missing coprocessor 0 register not flagged");
  chk_copy_out_exc: assert property (
    (exec && (cmd_reg.op == regmove_pkg::OP_SYS_CTL_COPY_OUT || cmd_reg.op == regmove_pkg::OP_FPU_COPY_OUT))
    |=> exc_reg inside {regmove_pkg::EXC_NONE, regmove_pkg::EXC_COP_UNUSABLE, regmove_pkg::EXC_RESERVED_INSTR})
    else $error("copy-out raised a forbidden exception");
  chk_fpu_word: assert property (
    (exec && cmd_reg.op == regmove_pkg::OP_FPU_COPY_OUT && cfg_reg[`RM_CFG_CU1]) |-> int_we && int_wd == fp_a[31:0])
    else $error("fp copy-out word wrong");
  chk_cop_two_exc: assert property (
    (exec && cmd_reg.op == regmove_pkg::OP_COP_TWO_COPY_OUT)
    |=> exc_reg == (cfg_reg[`RM_CFG_CU2] ? regmove_pkg::EXC_NONE : regmove_pkg::EXC_COP_UNUSABLE))
    else $error("coprocessor 2 copy-out exception wrong");
  chk_fpu_upper: assert property (
    (exec && cmd_reg.op == regmove_pkg::OP_FPU_UPPER_COPY && cfg_reg[`RM_CFG_CU1] && cfg_reg[`RM_CFG_REL2])
    |-> int_we && int_wd == fp_a[63:32])
    else $error("fp upper copy wrong");
  chk_pre_rel2: assert property (
    (exec && (cmd_reg.op == regmove_pkg::OP_FPU_UPPER_COPY || cmd_reg.op == regmove_pkg::OP_COP_TWO_UPPER_COPY)
     && op_usable(cmd_reg.op, cfg_reg) && !cfg_reg[`RM_CFG_REL2])
    |-> !int_we ##1 exc_reg == regmove_pkg::EXC_RESERVED_INSTR)
    else $error("upper copy before release 2 not reserved");
  chk_mul_copy: assert property (
    (exec && cmd_reg.op == regmove_pkg::OP_BOTTOM_MUL_COPY) |-> int_wd == lo_reg ##1 exc_reg == regmove_pkg::EXC_NONE)
    else $error("bottom multiply copy wrong");
  chk_cond_int: assert property (
    (exec && cmd_reg.op == regmove_pkg::OP_INT_MOVE_IF_COND_CLEAR && cfg_reg[`RM_CFG_CU1]) |-> int_we == !flag_lo)
    else $error("integer conditional move ignored flag");
  chk_fp_cond_hold: assert property (
    (exec && cmd_reg.op == regmove_pkg::OP_FP_MOVE_IF_COND_CLEAR && fp_we
     && cmd_reg.operand_format_field != regmove_pkg::FMT_PAIRED_SINGLE) |-> fp_wd == (flag_lo ? fp_b : fp_a))
    else $error("fp conditional move wrong");
  chk_fp_no_arith: assert property (
    (exec && (cmd_reg.op == regmove_pkg::OP_FP_REG_COPY || cmd_reg.op == regmove_pkg::OP_FP_MOVE_IF_COND_CLEAR)
     && cfg_reg[`RM_CFG_CU1] && cmd_reg.operand_format_field != regmove_pkg::FMT_RESERVED)
    |=> exc_reg == regmove_pkg::EXC_NONE)
    else $error("fp move raised an exception");

  cov_ps_merge: cover property (exec && cmd_reg.op == regmove_pkg::OP_FP_MOVE_IF_COND_CLEAR && flag_lo != flag_hi
    && cmd_reg.operand_format_field == regmove_pkg::FMT_PAIRED_SINGLE);
  cov_pre_rel2: cover property (exec && cmd_reg.op == regmove_pkg::OP_COP_TWO_UPPER_COPY && !cfg_reg[`RM_CFG_REL2]);
  cov_write_stall: cover property (write && waitrequest);

endmodule

// [regmove_map.svh]
// Register offsets, field positions and reset values of the register-move datapath.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
`ifndef REGMOVE_MAP_SVH
`define REGMOVE_MAP_SVH

// Register byte offsets
`define RM_OFF_CMD 8'h00
`define RM_OFF_CFG 8'h04
`define RM_OFF_STATUS 8'h08
`define RM_OFF_RESULT 8'h0c
`define RM_OFF_RESULT_HI 8'h10
`define RM_OFF_FCC 8'h14
`define RM_OFF_HI 8'h18
`define RM_OFF_LO 8'h1c
`define RM_OFF_WDATA 8'h20
`define RM_OFF_WDATA_HI 8'h24

// Configuration bit positions and reset value
`define RM_CFG_REL2 0
`define RM_CFG_FR64 1
`define RM_CFG_CU0 2
`define RM_CFG_CU1 3
`define RM_CFG_CU2 4
`define RM_CFG_RESET 5'h1f

// Status bit positions
`define RM_ST_BUSY 0
`define RM_ST_EXC_LSB 1
`define RM_ST_UNPRED 3
`define RM_ST_MOVED 4

// Sizes of the coprocessor banks and flag reset value
`define RM_COP0_REGS 4'h8
`define RM_COP2_REGS 5'h04
`define RM_FCC_RESET 8'h00

`endif

// [regmove_mem.sv]
// Register-file memory: 32 words, two read ports with registered data, one write port.
// Assumes one clock; a read of a word written at the same edge returns the old word.
module regmove_mem #(
  parameter int WIDTH = 32
) (
  input wire logic clk_sys,
  input wire logic [4:0] raddr_a,
  input wire logic [4:0] raddr_b,
  output logic [WIDTH-1:0] rdata_a,
  output logic [WIDTH-1:0] rdata_b,
  input wire logic we,
  input wire logic [4:0] waddr,
  input wire logic [WIDTH-1:0] wdata
);

  logic [WIDTH-1:0] mem [32];

  // Write port
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read ports
  always_ff @(posedge clk_sys) begin
    rdata_a <= mem[raddr_a];
    rdata_b <= mem[raddr_b];
  end

endmodule

// [regmove_pkg.sv]
// Types shared by the register-move datapath.
// Assumes the offsets and bit positions of regmove_map.svh.
package regmove_pkg;

  // Operation codes
  typedef enum logic [3:0] {
    OP_SYS_CTL_COPY_OUT = 4'h0,
    OP_FPU_COPY_OUT = 4'h1,
    OP_COP_TWO_COPY_OUT = 4'h2,
    OP_FPU_UPPER_COPY = 4'h3,
    OP_COP_TWO_UPPER_COPY = 4'h4,
    OP_UPPER_MUL_COPY = 4'h5,
    OP_BOTTOM_MUL_COPY = 4'h6,
    OP_FP_REG_COPY = 4'h7,
    OP_INT_MOVE_IF_COND_CLEAR = 4'h8,
    OP_FP_MOVE_IF_COND_CLEAR = 4'h9,
    OP_LOAD_INT = 4'ha,
    OP_LOAD_FP = 4'hb,
    OP_LOAD_COP0 = 4'hc,
    OP_LOAD_COP2 = 4'hd,
    OP_READ_INT = 4'he,
    OP_READ_FP = 4'hf
  } op_t;

  // Operand formats
  typedef enum logic [1:0] {
    FMT_SINGLE = 2'h0,
    FMT_DOUBLE = 2'h1,
    FMT_PAIRED_SINGLE = 2'h2,
    FMT_RESERVED = 2'h3
  } fmt_t;

  // Exception outcome of the last operation
  typedef enum logic [1:0] {
    EXC_NONE = 2'h0,
    EXC_COP_UNUSABLE = 2'h1,
    EXC_RESERVED_INSTR = 2'h2,
    EXC_UNIMPL_OP = 2'h3
  } exc_t;

  // Sequencer states, Gray coded
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_READ = 2'h1,
    ST_EXEC = 2'h3
  } state_t;

  // Command word written to the command register
  typedef struct packed {
    logic [9:0] unused;
    logic [2:0] sub_index_field;
    logic [4:0] dst;
    logic [4:0] src;
    logic [2:0] cond_flag_index;
    fmt_t operand_format_field;
    op_t op;
  } cmd_t;

endpackage
